/* rtl/cmd_if.sv */
// Command input interface: clock-enable power states, chip-select masked
// decode, bank and mode register tracking, termination and write masking.
// Assumes all pins are asynchronous to clock and are synchronised here.
//
// Summary of operation
// [RL1] Termination enabled on data, mask, strobe pins
// [RL2] Termination input ignored when mode-disabled
// [RL3] Inputs captured at rising differential crossing
// [RL4] Output timing referenced to clock crossings
// [RL5] Clock enable gates internal clocking circuitry
// [RL6] Low clock enable selects power-down kind
// [RL7] Clock enable sampled synchronously for entry
// [RL8] Self refresh exit on asynchronous enable rise
// [RL9] Power-down keeps clock enable, termination buffers
// [RL10] Self refresh keeps only clock enable buffer
// [RL11] Registered-low chip select enables decoder
// [RL12] Command decoded from strobes plus select
// [RL13] Masked write bytes are not stored
// [RL14] Mask sampled on both strobe edges
// [RL15] Lower mask lower byte, upper mask upper
// [RL16] Bank inputs select command target bank
// [RL17] Bank inputs select mode register loaded
// [RL18] Mode register value from address inputs
// [RL19] Precharge all banks when bit ten high
// [RL20] Command mapping follows published truth table
`timescale 1ns/1ns
`include "cmd_if_defines.svh"
module cmd_if #(
  parameter int DIES = `NUM_DIES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ck,
  input wire logic ck_n,
  input wire logic cke,
  input wire logic odt,
  input wire cmd_if_pkg::cmd_pins_type cmd_pins,
  input wire logic [`BANK_W-1:0] bank_addr,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic dqs,
  input wire logic [DIES-1:0] ldm,
  input wire logic [DIES-1:0] udm,
  output cmd_if_pkg::cmd_out_type cmd_out,
  output logic cmd_valid,
  output cmd_if_pkg::pwr_type pwr_state,
  output logic clk_active,
  output logic cmd_buf_en,
  output logic odt_buf_en,
  output logic odt_en,
  output logic out_launch,
  output logic [2*DIES-1:0] byte_we_rise,
  output logic [2*DIES-1:0] byte_we_fall,
  output logic [`NUM_BANKS-1:0] bank_open,
  output logic [`ADDR_W-1:0] mr_mode,
  output logic [`ADDR_W-1:0] mr_ext1,
  output logic [`ADDR_W-1:0] mr_ext2,
  output logic [`ADDR_W-1:0] mr_ext3
);
  import cmd_if_pkg::*;

  localparam int SW = 2 + 1 + 1 + 4 + `BANK_W + `ADDR_W + 1 + 2 * DIES;

  // Every pin goes through two flops as one bus; skew between pins is
  // tolerated because the controller holds them stable around the crossing.
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  wire logic [SW-1:0] pins_raw = {
    ck,
    ck_n,
    cke,
    odt,
    cmd_pins,
    bank_addr,
    addr,
    dqs,
    ldm,
    udm
  };

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
    end
  end

  // The unpacking below must follow the concatenation order of pins_raw.
  wire logic s_ck = sync2_r[SW-1];
  wire logic s_ck_n = sync2_r[SW-2];
  wire logic s_cke = sync2_r[SW-3];
  wire logic s_odt = sync2_r[SW-4];
  wire cmd_pins_type s_cmd = sync2_r[SW-5 -: 4];
  wire logic [`BANK_W-1:0] s_ba = sync2_r[SW-9 -: `BANK_W];
  wire logic [`ADDR_W-1:0] s_addr = sync2_r[SW-9-`BANK_W -: `ADDR_W];
  wire logic s_dqs = sync2_r[2*DIES];
  wire logic [DIES-1:0] s_ldm = sync2_r[2*DIES-1 -: DIES];
  wire logic [DIES-1:0] s_udm = sync2_r[DIES-1:0];

  logic ck_prev_r;
  logic dqs_prev_r;
  logic cke_reg_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ck_prev_r <= 1'b0;
      dqs_prev_r <= 1'b0;
    end else begin
      ck_prev_r <= s_ck;
      dqs_prev_r <= s_dqs;
    end
  end

  // A crossing needs the true clock rising and the complement low.
  wire logic ck_cross = s_ck & ~ck_prev_r & ~s_ck_n; // see [RL3]
  wire logic dqs_rise = s_dqs & ~dqs_prev_r; // see [RL14]
  wire logic dqs_fall = ~s_dqs & dqs_prev_r; // see [RL14]
  wire logic cke_reg_nxt = ck_cross ? s_cke : cke_reg_r; // see [RL5] see [RL7]

  // Reserved codes and a high select fall to deselect or no-operation, so
  // they are never reported as commands.
  function automatic cmd_type decode(input cmd_pins_type p);
    unique case ({p.cs_n, p.ras_n, p.cas_n, p.we_n}) // see [RL20]
      4'b0111: decode = cmd_nop;
      4'b0000: decode = cmd_mrs;
      4'b0001: decode = cmd_refresh;
      4'b0010: decode = cmd_precharge;
      4'b0011: decode = cmd_activate;
      4'b0100: decode = cmd_write;
      4'b0101: decode = cmd_read;
      4'b0110: decode = cmd_nop;
      default: decode = cmd_deselect;
    endcase
  endfunction : decode

  pwr_type pwr_r;
  pwr_type pwr_nxt;
  wire logic all_idle = ~|bank_open;
  wire cmd_type dec_cmd = decode(s_cmd); // see [RL12]
  wire logic cs_sel = ~s_cmd.cs_n; // see [RL11]
  wire logic awake = (pwr_r == st_active);
  wire logic take = ck_cross & awake & cs_sel & (dec_cmd != cmd_nop);
  wire logic is_mrs = take & (dec_cmd == cmd_mrs);
  wire logic is_act = take & (dec_cmd == cmd_activate);
  wire logic is_pre = take & (dec_cmd == cmd_precharge);
  wire logic is_sref = take & (dec_cmd == cmd_refresh) & ~s_cke & cke_reg_r;

  // Self refresh exit is not gated by a clock crossing, since the
  // controller may stop the clock while the device refreshes itself.
  always_comb begin
    pwr_nxt = pwr_r;
    unique case (pwr_r)
      st_active: begin
        if (is_sref && all_idle) begin
          pwr_nxt = st_self_ref; // see [RL6]
        end else if (ck_cross && !s_cke && cke_reg_r) begin
          pwr_nxt = all_idle ? st_pd_pre : st_pd_act; // see [RL6] see [RL7]
        end
      end
      st_pd_pre, st_pd_act: begin
        if (ck_cross && s_cke) begin
          pwr_nxt = st_active; // see [RL7]
        end
      end
      st_self_ref: begin
        if (s_cke) begin
          pwr_nxt = st_active; // see [RL8]
        end
      end
    endcase
  end

  wire logic odt_allowed = (mr_ext1[`EMR1_ODT_LO] | mr_ext1[`EMR1_ODT_HI]); // see [RL2]
  wire logic odt_buf_nxt = (pwr_nxt != st_self_ref); // see [RL9] see [RL10]
  wire logic cmd_buf_nxt = (pwr_nxt == st_active); // see [RL9]

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pwr_r <= st_active;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // Clock enable is only believed at a crossing, except by self refresh exit, which reads it between two of them.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cke_reg_r <= 1'b0;
    end else begin
      cke_reg_r <= cke_reg_nxt; // see [RL5] see [RL7]
    end
  end

  function automatic logic [`NUM_BANKS-1:0] bank_bit(input logic [`BANK_W-1:0] b);
    bank_bit = '0;
    bank_bit[b] = 1'b1;
  endfunction : bank_bit

  // Bank state and mode registers.
  // An activate to an open bank keeps it open; row timing is the
  // controller's business and is not checked here.
  logic [`NUM_BANKS-1:0] bank_nxt;
  always_comb begin
    bank_nxt = bank_open;
    if (is_act) begin
      bank_nxt = bank_open | bank_bit(s_ba); // see [RL16]
    end else if (is_pre) begin
      if (s_addr[`AP_BIT]) begin
        bank_nxt = '0; // see [RL19]
      end else begin
        bank_nxt = bank_open & ~bank_bit(s_ba); // see [RL16] see [RL19]
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bank_open <= '0;
      mr_mode <= `MR_RESET;
      mr_ext1 <= `MR_RESET;
      mr_ext2 <= `MR_RESET;
      mr_ext3 <= `MR_RESET;
    end else begin
      bank_open <= bank_nxt;
      if (is_mrs) begin
        unique case (s_ba) // see [RL17]
          `MR_MODE: mr_mode <= s_addr; // see [RL18]
          `MR_EXT1: mr_ext1 <= s_addr; // see [RL18]
          `MR_EXT2: mr_ext2 <= s_addr; // see [RL18]
          `MR_EXT3: mr_ext3 <= s_addr; // see [RL18]
          default: ;
        endcase
      end
    end
  end

  // Commands reach the outputs one cycle after the crossing that took them;
  // the last accepted command stays on cmd_out until the next one.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_out <= '0;
      cmd_valid <= 1'b0;
    end else begin
      cmd_valid <= take; // see [RL11]
      if (take) begin
        cmd_out <= '{cmd: dec_cmd, bank: s_ba, addr: s_addr}; // see [RL12]
      end
    end
  end

  // Power outputs follow the next state, so the status never lags the
  // buffer and clocking enables that it explains.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pwr_state <= st_active;
      clk_active <= 1'b0;
      cmd_buf_en <= 1'b1;
      odt_buf_en <= 1'b1;
    end else begin
      pwr_state <= pwr_nxt;
      clk_active <= cke_reg_nxt & (pwr_nxt == st_active); // see [RL5]
      cmd_buf_en <= cmd_buf_nxt;
      odt_buf_en <= odt_buf_nxt;
    end
  end

  // Termination follows its pin at each crossing and drops at once on self
  // refresh entry, since the clock may stop before another crossing comes.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      odt_en <= 1'b0;
    end else if (ck_cross || pwr_nxt == st_self_ref) begin
      odt_en <= s_odt & odt_allowed & odt_buf_nxt; // see [RL1] see [RL2] see [RL10]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_launch <= 1'b0;
    end else begin
      out_launch <= ck_cross & awake; // see [RL4]
    end
  end

  // Write byte enables: one bit per byte lane, low lanes then high lanes.
  // Each strobe edge judges its own mask, so a mask that changes between the
  // two edges of one strobe cycle is honoured edge by edge.
  wire logic [2*DIES-1:0] mask_now = {s_udm, s_ldm}; // see [RL15]

  for (genvar lane = 0; lane < 2 * DIES; lane++) begin : g_lane
    wire logic store_rise = dqs_rise & ~mask_now[lane]; // see [RL13] see [RL14]
    wire logic store_fall = dqs_fall & ~mask_now[lane]; // see [RL13] see [RL14]
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        byte_we_rise[lane] <= 1'b0;
        byte_we_fall[lane] <= 1'b0;
      end else begin
        byte_we_rise[lane] <= store_rise;
        byte_we_fall[lane] <= store_fall;
      end
    end
  end
endmodule : cmd_if

/* shared/cmd_if_defines.svh */
// Constants for the DRAM command input interface.
// Assumes inclusion by bare name from package and design files.
`ifndef CMD_IF_DEFINES_SVH
`define CMD_IF_DEFINES_SVH
`define NUM_BANKS 8
`define BANK_W 3
`define ADDR_W 14
`define AP_BIT 10
`define MR_MODE 3'h0
`define MR_EXT1 3'h1
`define MR_EXT2 3'h2
`define MR_EXT3 3'h3
`define MR_RESET 14'h0000
`define EMR1_ODT_LO 2
`define EMR1_ODT_HI 6
`define NUM_DIES 5
`endif

/* shared/cmd_if_pkg.sv */
// Types for the DRAM command input interface.
// Assumes the defines header is on the include path.
`include "cmd_if_defines.svh"
package cmd_if_pkg;
  typedef enum logic [3:0] {
    cmd_nop, cmd_mrs, cmd_refresh, cmd_precharge, cmd_activate,
    cmd_write, cmd_read, cmd_deselect
  } cmd_type;
  typedef enum logic [1:0] {
    st_active, st_pd_pre, st_pd_act, st_self_ref
  } pwr_type;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } cmd_pins_type;
  typedef struct packed {
    cmd_type cmd;
    logic [`BANK_W-1:0] bank;
    logic [`ADDR_W-1:0] addr;
  } cmd_out_type;
endpackage : cmd_if_pkg

/* tb/cmd_if_checker.sv */
// Checker on the command interface outputs.
// Assumes it is bound to cmd_if, whose ports share these names.
`timescale 1ns/1ns
module cmd_if_checker
  import cmd_if_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire cmd_if_pkg::cmd_out_type cmd_out,
  input wire logic cmd_valid,
  input wire cmd_if_pkg::pwr_type pwr_state,
  input wire logic clk_active,
  input wire logic cmd_buf_en,
  input wire logic odt_buf_en,
  input wire logic odt_en,
  input wire logic [7:0] bank_open,
  input wire logic [13:0] mr_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_act;
    cmd_valid && cmd_out.cmd == cmd_activate;
  endsequence
  sequence s_pre_all;
    cmd_valid && cmd_out.cmd == cmd_precharge && cmd_out.addr[10];
  endsequence
  a_sr_bufs: assert property (pwr_state == st_self_ref |-> !odt_buf_en && !cmd_buf_en && !odt_en)
    else $error("buffer on in self refresh");
  a_pd_bufs: assert property (pwr_state inside {st_pd_pre, st_pd_act} |-> odt_buf_en && !cmd_buf_en)
    else $error("wrong buffers in power-down");
  a_clk_gate: assert property (clk_active |-> pwr_state == st_active)
    else $error("clocking on outside active");
  a_pd_kind: assert property ($changed(pwr_state) && pwr_state == st_pd_act |-> $past(bank_open) != 8'h00)
    else $error("active power-down with banks idle");
  a_valid_once: assert property (cmd_valid |=> !cmd_valid [*8])
    else $error("command reported twice");
  a_act_open: assert property (s_act |-> bank_open[cmd_out.bank])
    else $error("activated bank not open");
  a_pre_all: assert property (s_pre_all |-> bank_open == 8'h00)
    else $error("banks open after precharge all");
  a_mrs_mode: assert property (cmd_valid && cmd_out.cmd == cmd_mrs && cmd_out.bank == 3'h0 |-> mr_mode == cmd_out.addr)
    else $error("mode register not loaded");
endmodule : cmd_if_checker
bind cmd_if cmd_if_checker cmd_if_checker_inst (.clock(clock), .rst_n(rst_n), .cmd_out(cmd_out),
  .cmd_valid(cmd_valid), .pwr_state(pwr_state), .clk_active(clk_active), .cmd_buf_en(cmd_buf_en),
  .odt_buf_en(odt_buf_en), .odt_en(odt_en), .bank_open(bank_open), .mr_mode(mr_mode));

/* tb/ctrl_model.sv */
// Memory controller model driving clock, command, level and mask pins.
// Assumes the bench calls its tasks one at a time, except lvl alongside send.
`timescale 1ns/1ns
module ctrl_model
  import cmd_if_pkg::*;
#(parameter int DIES = 5)
(
  output logic ck,
  output logic ck_n,
  output logic cke,
  output logic odt,
  output cmd_if_pkg::cmd_pins_type cmd_pins,
  output logic [2:0] bank_addr,
  output logic [13:0] addr,
  output logic dqs,
  output logic [DIES-1:0] ldm,
  output logic [DIES-1:0] udm
);
  logic run = 1'b1;
  assign ck_n = ~ck;
  // Pins move by non-blocking assignment, so a change that lands on a device
  // clock edge is seen one edge later and never races the sampling flops.
  initial begin
    {ck, odt, dqs, ldm, udm, bank_addr, addr} = '0;
    cke = 1'b1;
    cmd_pins = 4'hf;
    forever begin
      #62 ck <= run;
      #63 ck <= 1'b0;
    end
  end
  // Pins change at the falling edge so they are settled at the rising crossing.
  task automatic send(input cmd_pins_type p, input logic [2:0] b, input logic [13:0] a);
    @(negedge ck);
    cmd_pins <= p;
    bank_addr <= b;
    addr <= a;
    @(posedge ck);
    #20 cmd_pins <= 4'hf;
  endtask : send
  task automatic lvl(input logic e, input logic o);
    @(negedge ck);
    cke <= e;
    odt <= o;
  endtask : lvl
  // The clock may be stopped in self refresh, so enable rises at once.
  task automatic wake;
    cke <= 1'b1;
  endtask : wake
  task automatic hold_ck(input logic r);
    run = r;
  endtask : hold_ck
  task automatic strobe(input logic r, input logic [DIES-1:0] l, input logic [DIES-1:0] u);
    ldm <= l;
    udm <= u;
    #8 dqs <= r;
  endtask : strobe
endmodule : ctrl_model

/* tb/tb_cmd_if.sv */
// Self-checking bench for cmd_if with a controller model on its pins.
// Assumes package, design, checker and model are compiled first.
`timescale 1ns/1ns
module tb_cmd_if;
  import cmd_if_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ck, ck_n, cke, odt, dqs, cmd_valid, clk_active, cmd_buf_en, odt_buf_en, odt_en, got, launch;
  logic [4:0] ldm, udm;
  logic [2:0] ba;
  logic [13:0] a, mr_mode, mr_ext1, mr_ext2, mr_ext3;
  logic [9:0] we_r, we_f;
  logic [7:0] bank_open;
  cmd_pins_type pins;
  cmd_out_type cmd_out;
  pwr_type pwr_state;
  int error_cnt = 0;
  int n_compared = 0;
  initial begin
    forever #2 clock = ~clock;
  end
  ctrl_model ctrl_model_inst (.ck(ck), .ck_n(ck_n), .cke(cke), .odt(odt), .cmd_pins(pins),
    .bank_addr(ba), .addr(a), .dqs(dqs), .ldm(ldm), .udm(udm));
  cmd_if cmd_if_inst (.clock(clock), .rst_n(rst_n), .ck(ck), .ck_n(ck_n), .cke(cke), .odt(odt),
    .cmd_pins(pins), .bank_addr(ba), .addr(a), .dqs(dqs), .ldm(ldm), .udm(udm), .cmd_out(cmd_out),
    .cmd_valid(cmd_valid), .pwr_state(pwr_state), .clk_active(clk_active), .cmd_buf_en(cmd_buf_en),
    .odt_buf_en(odt_buf_en), .odt_en(odt_en), .out_launch(launch), .byte_we_rise(we_r), .byte_we_fall(we_f),
    .bank_open(bank_open), .mr_mode(mr_mode), .mr_ext1(mr_ext1), .mr_ext2(mr_ext2), .mr_ext3(mr_ext3));
  task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] s);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cmd(input logic [3:0] p, input logic [2:0] b, input logic [13:0] v);
    got = 1'b0;
    fork
      ctrl_model_inst.send(p, b, v);
      repeat (60) @(negedge clock) if (cmd_valid === 1'b1) got = 1'b1;
    join
  endtask : cmd
  task automatic settle;
    repeat (40) @(negedge clock);
  endtask : settle
  // 125 cycles span exactly four periods of the 125 ns link clock.
  task automatic launches(output logic [13:0] n);
    n = '0;
    repeat (125) @(negedge clock) n += 14'(launch);
  endtask : launches
  task automatic t_mrs;
    for (int i = 0; i < 4; i++) begin
      cmd(4'h0, 3'(i), 14'h0040 + 14'(i));
      chk("mrs", 14'h0001, 14'(got));
    end
    // A load aimed past the four registers is still reported but writes none.
    cmd(4'h0, 3'h4, 14'h3fff);
    chk("mrs bank4", 14'h0001, 14'(got));
    chk("mr_mode", 14'h0040, mr_mode);
    chk("mr_ext1", 14'h0041, mr_ext1);
    chk("mr_ext2", 14'h0042, mr_ext2);
    chk("mr_ext3", 14'h0043, mr_ext3);
    $display("t_mrs done");
  endtask : t_mrs
  task automatic t_cmd;
    logic [13:0] n;
    cmd(4'hb, 3'h5, 14'h0000);
    chk("masked", 14'h0000, 14'(got));
    cmd(4'h3, 3'h5, 14'h0000);
    chk("act", 14'(cmd_activate), 14'(cmd_out.cmd));
    chk("open", 14'h0020, 14'(bank_open));
    cmd(4'h4, 3'h5, 14'h0000);
    chk("wr", 14'(cmd_write), 14'(cmd_out.cmd));
    cmd(4'h5, 3'h5, 14'h0000);
    chk("rd", 14'(cmd_read), 14'(cmd_out.cmd));
    launches(n);
    chk("launch act", 14'h0004, n);
    $display("t_cmd done");
  endtask : t_cmd
  task automatic t_odt;
    ctrl_model_inst.lvl(1'b1, 1'b1);
    settle;
    chk("odt on", 14'h0001, 14'(odt_en));
    cmd(4'h0, 3'h1, 14'h0000);
    settle;
    chk("odt off", 14'h0000, 14'(odt_en));
    $display("t_odt done");
  endtask : t_odt
  task automatic t_pd;
    logic [13:0] n;
    ctrl_model_inst.lvl(1'b0, 1'b1);
    settle;
    chk("pd act", 14'(st_pd_act), 14'(pwr_state));
    chk("pd bufs", 14'h0002, 14'({cmd_buf_en, odt_buf_en, clk_active}));
    launches(n);
    chk("launch pd", 14'h0000, n);
    ctrl_model_inst.lvl(1'b1, 1'b0);
    settle;
    chk("clk on", 14'h0001, 14'(clk_active));
    cmd(4'h3, 3'h2, 14'h0000);
    cmd(4'h2, 3'h5, 14'h0000);
    chk("pre one", 14'h0004, 14'(bank_open));
    cmd(4'h2, 3'h0, 14'h0400);
    chk("pre all", 14'h0000, 14'(bank_open));
    ctrl_model_inst.lvl(1'b0, 1'b0);
    settle;
    chk("pd pre", 14'(st_pd_pre), 14'(pwr_state));
    ctrl_model_inst.lvl(1'b1, 1'b0);
    settle;
    chk("pd exit", 14'(st_active), 14'(pwr_state));
    $display("t_pd done");
  endtask : t_pd
  task automatic t_sr;
    fork
      ctrl_model_inst.lvl(1'b0, 1'b1);
      cmd(4'h1, 3'h0, 14'h0000);
    join
    settle;
    chk("sr", 14'(st_self_ref), 14'(pwr_state));
    chk("sr odt buf", 14'h0000, 14'(odt_buf_en));
    ctrl_model_inst.hold_ck(1'b0);
    settle;
    ctrl_model_inst.wake;
    repeat (10) @(negedge clock);
    chk("sr exit", 14'(st_active), 14'(pwr_state));
    ctrl_model_inst.hold_ck(1'b1);
    $display("t_sr done");
  endtask : t_sr
  task automatic t_mask;
    logic [9:0] s;
    s = '0;
    ctrl_model_inst.strobe(1'b1, 5'h15, 5'h0a);
    repeat (8) @(negedge clock) s |= we_r;
    chk("we rise", 14'h02aa, 14'(s));
    s = '0;
    ctrl_model_inst.strobe(1'b0, 5'h03, 5'h1c);
    repeat (8) @(negedge clock) s |= we_f;
    chk("we fall", 14'h007c, 14'(s));
    $display("t_mask done");
  endtask : t_mask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  initial begin
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    t_mrs;
    t_cmd;
    t_odt;
    t_pd;
    t_sr;
    t_mask;
    complete_run;
  end
  // The tests need about 6 us, so this limit leaves ample margin.
  initial begin
    #60000;
    error_cnt++;
    complete_run;
  end
endmodule : tb_cmd_if
